// >>> pbsc_chain.sv
// Purpose: Pad boundary scan chain with capture, shift and gated serial output
// Assumes: Scan pins are asynchronous to clk; strobe period well above 6 clk cycles
// Notes: Register access over APB with zero wait states
//
// Functional notes
// - Scan mode follows the scan enable level
// - Select low captures pads, high shifts chain
// - Inputs sampled at strobe rise, single or train
// - Serial output driven only while gate registered low
// - 67 positions, position 1 leaves first
// - Zeros follow after position 67 is out
// - Reserved pad positions always read zero
// - Pad mirroring disabled during scan mode
// - No memory command executes in scan mode
// - Scan: nominal address termination, data termination off
`timescale 1ns/1ps

module pbsc_chain
(
	input wire logic clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Scan pins from the tester
	input wire logic scan_mode_enable,
	input wire logic capture_shift_select,
	input wire logic scan_strobe,
	input wire logic scan_output_gate,
	input wire logic pad_mirror_select,
	input wire logic [pbsc_pkg::CHAIN_LEN-1:0] pad_levels,
	output logic scan_serial_output,
	output logic scan_serial_output_oe,
	// Memory command path and pad configuration
	input wire logic mem_cmd_valid,
	output logic mem_cmd_exec,
	output logic pad_mirror_active,
	output logic ca_term_nominal,
	output logic dq_term_enable
);

	localparam int N = pbsc_pkg::CHAIN_LEN;
	localparam int CW = pbsc_pkg::CNT_W;

	// Three-stage conditioning of the control pins
	logic [3:0] pin_s1_r;
	logic [3:0] pin_s2_r;
	logic [3:0] pin_s3_r;
	logic [3:0] pin_f_r;
	logic [N-1:0] pad_s1_r;
	logic [N-1:0] pad_s2_r;
	logic [N-1:0] pad_s3_r;
	logic [N-1:0] pad_f_r;
	logic [1:0] mir_s_r;
	logic mir_s3_r;
	logic mir_f_r;

	logic sen_f;
	logic ssh_f;
	logic stb_f;
	logic gate_f;
	logic stb_d_r;
	logic stb_rise;

	pbsc_pkg::pbsc_mode_t mode_r;
	logic scan_on;

	logic [N-1:0] chain_r;
	logic gate_r;
	logic capture_ev;
	logic shift_ev;

	logic [2:0] ctrl_r;
	logic [CW-1:0] captures_r;
	logic [CW-1:0] shifts_r;
	logic [CW-1:0] blocked_r;
	logic clr_pulse;
	logic blocked_ev;

	logic apb_setup;
	logic apb_write;
	logic [31:0] rdata_nxt;
	logic err_nxt;

	// Pin bundle: enable, select, strobe, gate
	assign sen_f = pin_f_r[0];
	assign ssh_f = pin_f_r[1];
	assign stb_f = pin_f_r[2];
	assign gate_f = pin_f_r[3];

	// Stage one feeds stage two only; a level is accepted once stages two and three agree
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_r <= 4'h8;
			pin_s2_r <= 4'h8;
			pin_s3_r <= 4'h8;
			pin_f_r <= 4'h8;
		end
		else
		begin
			pin_s1_r <= {scan_output_gate, scan_strobe, capture_shift_select, scan_mode_enable};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_f_r <= (pin_s2_r & ~(pin_s2_r ^ pin_s3_r)) | (pin_f_r & (pin_s2_r ^ pin_s3_r));
		end
	end

	// Pad levels go through the same conditioning so capture sees settled values
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pad_s1_r <= '0;
			pad_s2_r <= '0;
			pad_s3_r <= '0;
			pad_f_r <= '0;
		end
		else
		begin
			pad_s1_r <= pad_levels;
			pad_s2_r <= pad_s1_r;
			pad_s3_r <= pad_s2_r;
			pad_f_r <= (pad_s2_r & ~(pad_s2_r ^ pad_s3_r)) | (pad_f_r & (pad_s2_r ^ pad_s3_r));
		end
	end

	// Mirror select pin conditioning
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mir_s_r <= 2'h0;
			mir_s3_r <= 1'b0;
			mir_f_r <= 1'b0;
		end
		else
		begin
			mir_s_r <= {mir_s_r[0], pad_mirror_select};
			mir_s3_r <= mir_s_r[1];
			if (mir_s_r[1] == mir_s3_r)
				mir_f_r <= mir_s_r[1];
		end
	end

	// Strobe edge finder; works the same for a lone pulse or a train
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			stb_d_r <= 1'b0;
		else
			stb_d_r <= stb_f;
	end

	assign stb_rise = stb_f & ~stb_d_r;

	// Scan mode tracks the conditioned enable level directly
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mode_r <= pbsc_pkg::PBSC_SCAN_OFF;
		else
			mode_r <= sen_f ? pbsc_pkg::PBSC_SCAN_ON : pbsc_pkg::PBSC_SCAN_OFF;
	end

	assign scan_on = (mode_r == pbsc_pkg::PBSC_SCAN_ON);

	// Capture or shift decided by select level at the strobe rise
	assign capture_ev = scan_on & stb_rise & ~ssh_f;
	assign shift_ev = scan_on & stb_rise & ssh_f;

	// Chain: parallel load of every position, or one step toward the output with ground fed in
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			chain_r <= '0;
		else if (capture_ev)
			chain_r <= pad_f_r & ~pbsc_pkg::RSVD_MASK;
		else if (shift_ev)
			chain_r <= {1'b0, chain_r[N-1:1]};
	end

	// Output gate is registered at the strobe rise; leaving scan closes it again
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			gate_r <= 1'b1;
		else if (!scan_on)
			gate_r <= 1'b1;
		else if (stb_rise)
			gate_r <= gate_f;
	end

	// Position 1 sits at bit 0 and is always what the pin shows
	assign scan_serial_output = chain_r[0];
	assign scan_serial_output_oe = scan_on & ~gate_r;

	// Mirroring and termination are overridden while scanning
	assign pad_mirror_active = mir_f_r & ~scan_on;
	assign ca_term_nominal = scan_on | ctrl_r[pbsc_pkg::CTRL_CA_TERM_BIT];
	assign dq_term_enable = ~scan_on & ctrl_r[pbsc_pkg::CTRL_DQ_TERM_BIT];

	// Command gate: registered so the executed pulse is one clean cycle
	assign blocked_ev = mem_cmd_valid & scan_on;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mem_cmd_exec <= 1'b0;
		else
			mem_cmd_exec <= mem_cmd_valid & ~scan_on;
	end

	// APB decode; zero wait states, read data latched in the setup cycle
	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pwrite & ~pslverr;
	assign pready = psel & penable;
	assign clr_pulse = apb_write && (paddr == pbsc_pkg::OFS_CTRL) && pwdata[pbsc_pkg::CTRL_CLR_BIT];

	// Control register; bit 0 is a self-clearing counter clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_r <= pbsc_pkg::CTRL_RESET;
		else if (apb_write && (paddr == pbsc_pkg::OFS_CTRL))
			ctrl_r <= {pwdata[pbsc_pkg::CTRL_CA_TERM_BIT], pwdata[pbsc_pkg::CTRL_DQ_TERM_BIT], 1'b0};
	end

	// Event counters; a coinciding event survives the clear as a count of one
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			captures_r <= '0;
			shifts_r <= '0;
			blocked_r <= '0;
		end
		else
		begin
			if (clr_pulse)
			begin
				captures_r <= {{(CW-1){1'b0}}, capture_ev};
				shifts_r <= {{(CW-1){1'b0}}, shift_ev};
				blocked_r <= {{(CW-1){1'b0}}, blocked_ev};
			end
			else
			begin
				captures_r <= captures_r + {{(CW-1){1'b0}}, capture_ev};
				shifts_r <= shifts_r + {{(CW-1){1'b0}}, shift_ev};
				blocked_r <= blocked_r + {{(CW-1){1'b0}}, blocked_ev};
			end
		end
	end

	// Read mux; unmapped offsets answer with an error and zero data
	always_comb
	begin
		rdata_nxt = 32'h0;
		err_nxt = 1'b0;
		unique case (paddr)
			pbsc_pkg::OFS_CTRL:
				rdata_nxt = {29'h0, ctrl_r};
			pbsc_pkg::OFS_STATUS:
			begin
				rdata_nxt[pbsc_pkg::STAT_SCAN_BIT] = scan_on;
				rdata_nxt[pbsc_pkg::STAT_SCAN_SERIAL_OUTPUT_BIT] = chain_r[0];
				rdata_nxt[pbsc_pkg::STAT_OE_BIT] = scan_serial_output_oe;
				rdata_nxt[pbsc_pkg::STAT_MIRROR_BIT] = pad_mirror_active;
				rdata_nxt[pbsc_pkg::STAT_GATE_BIT] = gate_r;
			end
			pbsc_pkg::OFS_CAPTURES:
				rdata_nxt = {16'h0, captures_r};
			pbsc_pkg::OFS_SHIFTS:
				rdata_nxt = {16'h0, shifts_r};
			pbsc_pkg::OFS_BLOCKED:
				rdata_nxt = {16'h0, blocked_r};
			default:
				err_nxt = 1'b1;
		endcase
	end

	// Answer registers held through the access phase
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end
		else if (apb_setup)
		begin
			prdata <= pwrite ? 32'h0 : rdata_nxt;
			pslverr <= err_nxt;
		end
		else if (!psel)
		begin
			pslverr <= 1'b0;
		end
	end

endmodule

// >>> pbsc_pkg.sv
// Purpose: Shared constants for the pad boundary scan chain block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Chain position N sits at vector bit N-1; position 1 leaves first
package pbsc_pkg;

	// Chain geometry
	localparam int CHAIN_LEN = 67;
	localparam int RSVD_POS_A = 57;
	localparam int RSVD_POS_B = 58;
	localparam logic [CHAIN_LEN-1:0] RSVD_MASK =
		(67'h1 << (RSVD_POS_A - 1)) | (67'h1 << (RSVD_POS_B - 1));

	// Input conditioning depth for pins from outside the clock domain
	localparam int SYNC_DEPTH = 3;

	// APB register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CAPTURES = 8'h08;
	localparam logic [7:0] OFS_SHIFTS = 8'h0c;
	localparam logic [7:0] OFS_BLOCKED = 8'h10;

	// Control register fields
	localparam int CTRL_CLR_BIT = 0;
	localparam int CTRL_DQ_TERM_BIT = 1;
	localparam int CTRL_CA_TERM_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h6;

	// Status register fields
	localparam int STAT_SCAN_BIT = 0;
	localparam int STAT_SCAN_SERIAL_OUTPUT_BIT = 1;
	localparam int STAT_OE_BIT = 2;
	localparam int STAT_MIRROR_BIT = 3;
	localparam int STAT_GATE_BIT = 4;

	// Event counter width
	localparam int CNT_W = 16;

	// Scan mode state
	typedef enum logic [0:0] {
		PBSC_SCAN_OFF = 1'b0,
		PBSC_SCAN_ON = 1'b1
	} pbsc_mode_t;

endpackage

// >>> pbsc_chain_props.sv
// Purpose: Port assertions for the pad scan chain
// Assumes: Scan pins reach the chain about 5 clk late
// Notes: Level counters saturate at 15
`timescale 1ns/1ps
module pbsc_chain_props
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scan_mode_enable,
	input wire logic scan_strobe,
	input wire logic scan_serial_output,
	input wire logic scan_serial_output_oe,
	input wire logic mem_cmd_valid,
	input wire logic mem_cmd_exec,
	input wire logic pad_mirror_active,
	input wire logic ca_term_nominal,
	input wire logic dq_term_enable
);
	logic [3:0] hi_r, lo_r, age_r;
	logic str_r;
	// Pin level ages; margins cover the input conditioning lag
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hi_r <= 4'h0;
			lo_r <= 4'h0;
			age_r <= 4'hf;
			str_r <= 1'b0;
		end
		else
		begin
			hi_r <= scan_mode_enable ? hi_r + 4'(hi_r != 4'hf) : 4'h0;
			lo_r <= scan_mode_enable ? 4'h0 : lo_r + 4'(lo_r != 4'hf);
			str_r <= scan_strobe;
			age_r <= (scan_strobe && !str_r) ? 4'h1 : age_r + 4'(age_r != 4'hf);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_access;
		psel && !penable ##1 psel && penable;
	endsequence
	a_ready_access: assert property (s_access |-> pready) else $error("no ready");
	a_unmapped_err: assert property (psel && !penable && paddr > 8'h10 ##1 psel && penable |-> pslverr)
		else $error("no slverr");
	a_scan_term: assert property (hi_r > 4'h7 |-> ca_term_nominal && !dq_term_enable) else $error("term");
	a_cmd_blocked: assert property (hi_r > 4'h7 |-> !mem_cmd_exec) else $error("cmd in scan");
	a_exec_cause: assert property (mem_cmd_exec |-> $past(mem_cmd_valid)) else $error("stray exec");
	a_mirror_off: assert property (pad_mirror_active |-> hi_r < 4'h8) else $error("mirror");
	a_oe_idle: assert property (lo_r > 4'h6 |-> !scan_serial_output_oe) else $error("oe idle");
	a_out_window: assert property ($changed(scan_serial_output) |-> age_r >= 4'h2 && age_r <= 4'h8)
		else $error("out moved");
endmodule
bind pbsc_chain pbsc_chain_props chk_u (.*);

// >>> pbsc_tester.sv
// Purpose: Board tester model driving the scan pins
// Assumes: Pulses start right after a rising clk edge
// Notes: Strobe rests low between pulses
`timescale 1ns/1ps
module pbsc_tester
(
	input wire logic clk,
	output logic scan_mode_enable,
	output logic capture_shift_select,
	output logic scan_strobe,
	output logic scan_output_gate,
	output logic [pbsc_pkg::CHAIN_LEN-1:0] pad_levels
);
	// Scan off and gate disabled until the bench asks
	initial
	begin
		scan_mode_enable = 1'b0;
		capture_shift_select = 1'b1;
		scan_strobe = 1'b0;
		scan_output_gate = 1'b1;
		pad_levels = '0;
	end
	// One 400 ns strobe; select and gate held 2 clk around the rise
	task automatic pulse(input logic s, input logic g);
		capture_shift_select <= s;
		scan_output_gate <= g;
		repeat (2) @(posedge clk);
		scan_strobe <= 1'b1;
		repeat (4) @(posedge clk);
		scan_strobe <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
endmodule

// >>> pbsc_chain_test.sv
// Purpose: Self-checking bench for the pad scan chain
// Assumes: APB answers with no wait states
// Notes: Reserved pads are driven high to show they read zero
`timescale 1ns/1ps
module pbsc_chain_test;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, mem_cmd_valid = 0, pad_mirror_select = 0, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, scan_mode_enable, capture_shift_select, scan_strobe, scan_output_gate;
	logic scan_serial_output, scan_serial_output_oe, mem_cmd_exec, pad_mirror_active, ca_term_nominal, dq_term_enable;
	logic [66:0] pad_levels;
	logic [66:0] pat = 67'h5_a3c9_6e17_d2b4_8f1d | pbsc_pkg::RSVD_MASK;
	int failures = 0, samples_checked = 0, cyc = 0;
	pbsc_tester tst (.*);
	pbsc_chain dut_u (.*);
	// Clock and hang guard
	always #50 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			failures++;
			report_and_stop;
		end
	end
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x)
		begin
			failures++;
			$display("ERROR %s expected %h got %h", n, x, g);
		end
	endtask
	// One APB transfer, held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		// One idle edge so back-to-back calls never drive psel twice in a step
		@(posedge clk);
	endtask
	task automatic cmd(input logic x);
		mem_cmd_valid <= 1;
		@(posedge clk);
		mem_cmd_valid <= 0;
		@(posedge clk);
		chk("exec", x, mem_cmd_exec);
	endtask
	task automatic report_and_stop;
		if (failures == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Registers, normal mode, then scan entry, capture, full shift-out and exit
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1;
		apb(0, 8'h00, 0);
		chk("ctrl", 32'h6, r);
		apb(0, 8'h14, 0);
		chk("slverr", 1, e);
		apb(1, 8'h00, 32'h2);
		chk("dq_term", 1, dq_term_enable);
		chk("ca_term", 0, ca_term_nominal);
		pad_mirror_select <= 1;
		repeat (6) @(posedge clk);
		chk("mirror", 1, pad_mirror_active);
		cmd(1);
		tst.scan_mode_enable <= 1;
		repeat (8) @(posedge clk);
		chk("mirror", 0, pad_mirror_active);
		chk("ca_term", 1, ca_term_nominal);
		chk("dq_term", 0, dq_term_enable);
		cmd(0);
		apb(0, 8'h10, 0);
		chk("blocked", 1, r);
		tst.pad_levels <= pat;
		tst.pulse(0, 0);
		chk("oe", 1, scan_serial_output_oe);
		chk("pos1", pat[0], scan_serial_output);
		for (int i = 1; i < 70; i++)
		begin
			tst.pulse(1, 0);
			chk("shift", (i < 67 && !pbsc_pkg::RSVD_MASK[i]) ? pat[i] : 1'b0, scan_serial_output);
		end
		tst.pulse(1, 1);
		chk("oe", 0, scan_serial_output_oe);
		tst.pad_levels <= 67'h1;
		tst.pulse(0, 0);
		chk("pos1", 1, scan_serial_output);
		tst.scan_mode_enable <= 0;
		repeat (8) @(posedge clk);
		chk("oe", 0, scan_serial_output_oe);
		chk("mirror", 1, pad_mirror_active);
		tst.pulse(1, 0);
		chk("held", 1, scan_serial_output);
		chk("dq_term", 1, dq_term_enable);
		apb(0, 8'h04, 0);
		chk("status", 32'h1a, r);
		apb(0, 8'h08, 0);
		chk("captures", 2, r);
		apb(0, 8'h0c, 0);
		chk("shifts", 32'h46, r);
		apb(1, 8'h00, 32'h3);
		apb(0, 8'h08, 0);
		chk("cleared", 0, r);
		// Reset pulse on rst_n before normal use again
		rst_n <= 0;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		apb(0, 8'h00, 0);
		chk("ctrl", 32'h6, r);
		chk("scan_serial_output", 0, scan_serial_output);
		cmd(1);
		report_and_stop;
	end
endmodule
